// ==== ocl_host_model.sv ====
// USB host model that fetches string characters from the loader.
// Assumes the loader answers each request with a one-cycle str_ack.
`timescale 1ns/1ps
`default_nettype none
module ocl_host_model
(
	// Clock
	input wire logic clk_sys,
	// String answer
	input wire logic str_ack,
	input wire logic str_ok,
	input wire logic [7:0] str_char,
	// String request
	output logic str_req,
	output logic [1:0] str_sel,
	output logic [2:0] str_idx
);
	// Idle request lines at time zero
	initial
	begin
		str_req = 1'b0;
		str_sel = 2'h3;
		str_idx = 3'h7;
	end

	// ==========================================================
	// One fetch: the gap sets how slowly the host asks
	task automatic fetch(input logic [1:0] sel, input logic [2:0] idx, input int gap,
		output logic ok, output logic [7:0] ch);
		repeat (gap + 1) @(posedge clk_sys);
		str_req <= 1'b1;
		str_sel <= sel;
		str_idx <= idx;
		do
			@(posedge clk_sys);
		while (str_ack !== 1'b1);
		// Answer taken at the edge that sees the acknowledge, then released
		ok = str_ok;
		ch = str_char;
		str_req <= 1'b0;
		// Released lines must not keep showing the last request
		str_sel <= ~sel;
		str_idx <= ~idx;
	endtask
endmodule
`default_nettype wire

// ==== ocl_loader.sv ====
// Configuration loader: reads stored settings, presents them to the USB
// and pin logic, and shapes the pins during suspend.
// Assumes an AHB-Lite master for registers and USB logic on clk_sys.
//
// Behaviour
// - Reload all settings after power-on reset and after every USB reset.
// - Report USB version 0200h always, whatever speed the link runs.
// - Report bus or self powered from the stored power-source bit.
// - Report current up to 500 mA; zero when self powered.
// - Advertise remote wake-up from the stored wake bit.
// - Return the 16-bit vendor and product identifiers.
// - Serve stored maker and product strings on request.
// - Serve the serial string on selector 2 only when its stored enable is set; selector 3 serves it whatever the enable.
// - Device type is read only; software cannot change it.
// - When enabled, general pin two shows USB suspend.
// - Suspend indicator follows stored polarity, high while suspended by default.
// - Slave address is the stored 7-bit value.
// - Serial pins tri-state on suspend unless pin control mode is stored.
// - In pin control mode serial pins keep, drive high or drive low.
// - General pins keep, tri-state, drive high or low on suspend.
// - Open-drain option makes general pins drive low only.
// - Charger output works unless its stored disable is set.
// - Charger output uses the stored polarity, active high by default.
// - Wake input on general pin three triggers on the stored edge.
// - Charger output active only while suspended and a charger port seen.
`timescale 1ns/1ps
`default_nettype none
module ocl_loader
#(
	parameter int SER_PINS = 6
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// USB device logic
	input wire logic usb_reset_i,
	input wire logic usb_suspend,
	input wire logic dcp_detect,
	output logic desc_valid,
	output logic [15:0] desc_vid,
	output logic [15:0] desc_pid,
	output logic [15:0] desc_version,
	output logic [15:0] dev_type,
	output logic desc_self_powered,
	output logic [8:0] desc_max_current,
	output logic desc_remote_wake,
	output logic desc_serial_en,
	// String requests
	input wire logic str_req,
	input wire logic [1:0] str_sel,
	input wire logic [2:0] str_idx,
	output logic str_ack,
	output logic str_ok,
	output logic [7:0] str_char,
	// Serial slave
	output logic [6:0] slave_addr,
	// General pins
	input wire logic [3:0] gpio_out_i,
	input wire logic [3:0] gpio_oe_i,
	output logic [3:0] pin_out,
	output logic [3:0] pin_oe,
	input wire logic interrupt_wake_function,
	input wire logic general_pin_three,
	output logic wake_pulse,
	// Serial port pins
	input wire logic [SER_PINS-1:0] ser_out_i,
	input wire logic [SER_PINS-1:0] ser_oe_i,
	output logic [SER_PINS-1:0] ser_pin_out,
	output logic [SER_PINS-1:0] ser_pin_oe,
	// Charger detect
	output logic charger_detect_out
);
	import ocl_pkg::*;

	ocl_otp_if otp ();

	ocl_otp_mem u_mem
	(
		.clk_sys(clk_sys),
		.rstn(rstn),
		.otp(otp)
	);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	// ==========================================================
	// Input synchronisers
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic pin3_prev_q;
	wire logic susp_s = sync2_q[0];
	wire logic dcp_s = sync2_q[1];
	wire logic pin3_s = sync2_q[2];

	// Two flops per pin
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
			pin3_prev_q <= 1'b0;
		end
		else
		begin
			sync1_q <= {general_pin_three, dcp_detect, usb_suspend};
			sync2_q <= sync1_q;
			pin3_prev_q <= pin3_s;
		end
	end

	// ==========================================================
	// Loader state machine
	ocl_state_t state_q;
	ocl_state_t state_d;
	logic [5:0] cnt_q;
	logic [15:0] shadow_q [OCL_CFG_WORDS];
	logic [15:0] live_q [OCL_CFG_WORDS];
	logic valid_q;
	logic reload_q;
	logic ack_q;
	logic ok_q;
	logic [7:0] char_q;

	wire logic reload = usb_reset_i | reload_q;
	wire logic serial_on = live_q[3][OCL_FB_SERIAL];
	wire logic str_refuse = (str_sel == 2'h2) & ~serial_on;
	wire logic str_go = (state_q == OCL_ST_IDLE) & str_req & ~ack_q;
	wire logic [5:0] str_base = (str_sel == 2'h0) ? OCL_STR_MFR_BASE :
		(str_sel == 2'h1) ? OCL_STR_PROD_BASE : OCL_STR_SER_BASE;
	wire logic [5:0] str_addr = str_base + {3'h0, str_idx};

	// Store read port
	assign otp.req = (state_q == OCL_ST_READ) | (str_go & ~str_refuse);
	assign otp.addr = (state_q == OCL_ST_READ) ? cnt_q : str_addr;

	// Next state
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			OCL_ST_IDLE: if (str_go & ~str_refuse) state_d = OCL_ST_STR;
			OCL_ST_READ: state_d = OCL_ST_WAIT;
			OCL_ST_WAIT: if (otp.rvalid) state_d = (cnt_q == OCL_CFG_LAST) ? OCL_ST_COMMIT : OCL_ST_READ;
			OCL_ST_COMMIT: state_d = OCL_ST_IDLE;
			OCL_ST_STR: if (otp.rvalid) state_d = OCL_ST_IDLE;
			default: state_d = OCL_ST_READ;
		endcase
		if (reload)
			state_d = OCL_ST_READ;
	end

	// State, counter and valid flag
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q <= OCL_ST_READ;
			cnt_q <= 6'h00;
			valid_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			if (reload)
				cnt_q <= 6'h00;
			else if (state_q == OCL_ST_WAIT && otp.rvalid)
				cnt_q <= cnt_q + 6'h01;
			valid_q <= ~reload & (valid_q | (state_q == OCL_ST_COMMIT));
		end
	end

	// Shadow capture and single commit of every word
	genvar w;
	generate
		for (w = 0; w < OCL_CFG_WORDS; w++)
		begin : g_word
			localparam logic [15:0] DEF = (w == 0) ? OCL_DEF_DEVTYPE : (w == 1) ? OCL_DEF_VID :
				(w == 2) ? OCL_DEF_PID : (w == 3) ? OCL_DEF_FLAGS :
				(w == 4) ? OCL_DEF_POWER : OCL_DEF_SLAVE;
			always_ff @(posedge clk_sys or negedge rstn)
			begin
				if (!rstn)
				begin
					shadow_q[w] <= DEF;
					live_q[w] <= DEF;
				end
				else
				begin
					if (state_q == OCL_ST_WAIT && otp.rvalid && cnt_q == 6'(w))
						shadow_q[w] <= otp.rdata;
					if (state_q == OCL_ST_COMMIT)
						live_q[w] <= shadow_q[w];
				end
			end
		end
	endgenerate

	// String answer
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			ack_q <= 1'b0;
			ok_q <= 1'b0;
			char_q <= 8'h00;
		end
		else
		begin
			ack_q <= (str_go & str_refuse) | ((state_q == OCL_ST_STR) & otp.rvalid);
			ok_q <= ~(str_go & str_refuse);
			if (state_q == OCL_ST_STR && otp.rvalid)
				char_q <= otp.rdata[7:0];
		end
	end

	// ==========================================================
	// Descriptor fields
	wire logic [15:0] flags = live_q[3];
	wire logic [8:0] cur_raw = live_q[4][8:0];
	wire logic self_pwr = flags[OCL_FB_SELF_PWR];

	assign desc_valid = valid_q;
	assign desc_vid = live_q[1];
	assign desc_pid = live_q[2];
	assign desc_version = OCL_USB_VERSION;
	assign dev_type = live_q[0];
	assign desc_self_powered = self_pwr;
	assign desc_max_current = self_pwr ? 9'h000 :
		((cur_raw > OCL_MAX_CURRENT) ? OCL_MAX_CURRENT : cur_raw);
	assign desc_remote_wake = flags[OCL_FB_WAKE];
	assign desc_serial_en = serial_on;
	assign slave_addr = live_q[5][6:0];
	assign str_ack = ack_q;
	assign str_ok = ok_q;
	assign str_char = char_q;

	// ==========================================================
	// Pin behaviour in suspend
	wire logic susp_ind = susp_s ^ flags[OCL_FB_SUSP_POL];
	wire logic [1:0] pin_mode = flags[OCL_FB_PIN_SUSP+:2];
	wire logic [1:0] ser_mode = flags[OCL_FB_SER_SUSP+:2];
	wire logic od = flags[OCL_FB_OPEN_DRAIN];
	logic [3:0] held_out_q;
	logic [3:0] held_oe_q;
	logic [SER_PINS-1:0] sheld_out_q;
	logic [SER_PINS-1:0] sheld_oe_q;
	logic [3:0] raw_out;
	logic [3:0] raw_oe;

	// Remember pin states while awake
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			held_out_q <= 4'h0;
			held_oe_q <= 4'h0;
			sheld_out_q <= '0;
			sheld_oe_q <= '0;
		end
		else if (!susp_s)
		begin
			held_out_q <= gpio_out_i;
			held_oe_q <= gpio_oe_i;
			sheld_out_q <= ser_out_i;
			sheld_oe_q <= ser_oe_i;
		end
	end

	genvar i;
	generate
		for (i = 0; i < 4; i++)
		begin : g_pin
			wire logic s_out = (pin_mode == OCL_SUSP_KEEP) ? held_out_q[i] : (pin_mode == OCL_SUSP_HIGH);
			wire logic s_oe = (pin_mode == OCL_SUSP_KEEP) ? held_oe_q[i] : (pin_mode != OCL_SUSP_TRI);
			wire logic ind = (i == 2) & flags[OCL_FB_SUSP_EN];
			assign raw_out[i] = ind ? susp_ind : (susp_s ? s_out : gpio_out_i[i]);
			assign raw_oe[i] = ind ? 1'b1 : (susp_s ? s_oe : gpio_oe_i[i]);
			assign pin_out[i] = od ? 1'b0 : raw_out[i];
			assign pin_oe[i] = od ? (raw_oe[i] & ~raw_out[i]) : raw_oe[i];
		end
		for (i = 0; i < SER_PINS; i++)
		begin : g_ser
			wire logic keep = (ser_mode == OCL_SUSP_KEEP) | (ser_mode == OCL_SUSP_LOW);
			wire logic c_out = keep ? sheld_out_q[i] : (ser_mode == OCL_SUSP_TRI);
			wire logic c_oe = keep ? sheld_oe_q[i] : 1'b1;
			wire logic pinctl = flags[OCL_FB_SER_MODE];
			assign ser_pin_out[i] = ~susp_s ? ser_out_i[i] : (pinctl ? c_out : 1'b0);
			assign ser_pin_oe[i] = ~susp_s ? ser_oe_i[i] : (pinctl & c_oe);
		end
	endgenerate

	// ==========================================================
	// Charger output and wake edge
	wire logic chg_on = ~flags[OCL_FB_CHG_DIS] & susp_s & dcp_s;
	wire logic edge_hit = flags[OCL_FB_EDGE] ? (pin3_prev_q & ~pin3_s) : (~pin3_prev_q & pin3_s);
	logic chg_q;
	logic wake_q;

	// Registered pin outputs
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			chg_q <= 1'b0;
			wake_q <= 1'b0;
		end
		else
		begin
			chg_q <= chg_on ^ flags[OCL_FB_CHG_POL];
			wake_q <= interrupt_wake_function & edge_hit;
		end
	end
	assign charger_detect_out = chg_q;
	assign wake_pulse = wake_q;

	// ==========================================================
	// AHB-Lite register slave
	logic [31:0] rdata_q;
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	wire logic addr_ok = hsel & htrans[1] & hready;
	wire logic [7:0] roff = haddr[7:0];
	wire logic [31:0] rd_mux =
		(roff == OCL_REG_STATUS) ? {27'h0, charger_detect_out, dcp_s, susp_s,
			(state_q != OCL_ST_IDLE) & ~valid_q, valid_q} :
		(roff == OCL_REG_IDS) ? {desc_vid, desc_pid} :
		(roff == OCL_REG_INFO) ? {dev_type, desc_version} :
		(roff == OCL_REG_FLAGS) ? {16'h0, flags} :
		(roff == OCL_REG_POWER) ? {9'h0, slave_addr, 7'h0, desc_max_current} : 32'h0;

	// Address phase capture and write data phase
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			rdata_q <= 32'h0;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			reload_q <= 1'b0;
		end
		else
		begin
			if (addr_ok && !hwrite)
				rdata_q <= rd_mux;
			wr_pend_q <= addr_ok & hwrite;
			if (addr_ok)
				wr_addr_q <= roff;
			reload_q <= wr_pend_q & (wr_addr_q == OCL_REG_CTRL) & hwdata[0];
		end
	end
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_q;

	// ==========================================================
	// Checks
	sequence s_load_req;
		$rose(reload);
	endsequence
	sequence s_load_run;
		!desc_valid [*8];
	endsequence

	a_reload_clears: assert property (s_load_req |=> s_load_run)
		else $error("settings valid too soon after reload");
	a_version_fixed: assert property (desc_version == 16'h0200)
		else $error("usb version not 0200h");
	a_power_zero: assert property (desc_self_powered |-> desc_max_current == 9'h000)
		else $error("self powered but current not zero");
	a_current_cap: assert property (desc_max_current <= 9'h1F4)
		else $error("current above 500 mA");
	a_serial_gate: assert property (str_ack && str_sel == 2'h2 && !desc_serial_en |-> !str_ok)
		else $error("serial string served while disabled");
	a_pin_two: assert property (flags[OCL_FB_SUSP_EN] && !od |->
		pin_oe[2] && pin_out[2] == (susp_s ^ flags[OCL_FB_SUSP_POL]))
		else $error("suspend indicator wrong");
	a_open_drain: assert property (od |-> pin_out == 4'h0)
		else $error("open drain pin driven high");
	a_charger_gate: assert property (!$past(susp_s) |-> charger_detect_out == $past(flags[OCL_FB_CHG_POL]))
		else $error("charger output active while awake");
	a_commit_all: assert property ($rose(desc_valid) |-> $past(state_q) == OCL_ST_COMMIT)
		else $error("settings valid without commit");
	a_wake_edge: assert property (wake_pulse |-> $past(interrupt_wake_function))
		else $error("wake pulse without wake function");

endmodule
`default_nettype wire

// ==== ocl_otp_if.sv ====
// Read port between the loader and its configuration store.
// Assumes both ends on the system clock.
`timescale 1ns/1ps
`default_nettype none
interface ocl_otp_if;
	import ocl_pkg::*;
	logic req;
	logic [OCL_AW-1:0] addr;
	logic [OCL_DW-1:0] rdata;
	logic rvalid;
	modport loader (output req, output addr, input rdata, input rvalid);
	modport store (input req, input addr, output rdata, output rvalid);
endinterface
`default_nettype wire

// ==== ocl_otp_mem.sv ====
// Programmed configuration store, one word per read, data from a register.
// Assumes reads issued one at a time; answer comes one cycle later.
`timescale 1ns/1ps
`default_nettype none
module ocl_otp_mem
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Read port
	ocl_otp_if.store otp
);
	import ocl_pkg::*;

	// ==========================================================
	// Stored contents
	function automatic logic [OCL_DW-1:0] rom_word(input logic [OCL_AW-1:0] a);
		case (a)
			OCL_WI_DEVTYPE: rom_word = OCL_DEF_DEVTYPE;
			OCL_WI_VID: rom_word = OCL_DEF_VID;
			OCL_WI_PID: rom_word = OCL_DEF_PID;
			OCL_WI_FLAGS: rom_word = OCL_DEF_FLAGS;
			OCL_WI_POWER: rom_word = OCL_DEF_POWER;
			OCL_WI_SLAVE: rom_word = OCL_DEF_SLAVE;
			6'h08: rom_word = 16'h0041; // Maker text
			6'h09: rom_word = 16'h0043;
			6'h0A: rom_word = 16'h004D;
			6'h0B: rom_word = 16'h0045;
			6'h10: rom_word = 16'h0042; // Product text
			6'h11: rom_word = 16'h0052;
			6'h12: rom_word = 16'h0049;
			6'h13: rom_word = 16'h0044;
			6'h14: rom_word = 16'h0047;
			6'h15: rom_word = 16'h0045;
			6'h18: rom_word = 16'h0030; // Serial text
			6'h19: rom_word = 16'h0030;
			6'h1A: rom_word = 16'h0030;
			6'h1B: rom_word = 16'h0031;
			default: rom_word = 16'h0000;
		endcase
	endfunction

	// Registered read data
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			otp.rdata <= 16'h0000;
			otp.rvalid <= 1'b0;
		end
		else
		begin
			otp.rdata <= rom_word(otp.addr);
			otp.rvalid <= otp.req;
		end
	end

endmodule
`default_nettype wire

// ==== ocl_pkg.sv ====
// Constants, word layout and types of the configuration loader.
// Assumes a 16-bit wide configuration store read one word at a time.
package ocl_pkg;

	// ==========================================================
	// Store geometry
	localparam int OCL_DW = 16;
	localparam int OCL_AW = 6;
	localparam int OCL_CFG_WORDS = 6;
	localparam logic [5:0] OCL_CFG_LAST = 6'h05;

	// ==========================================================
	// Word indices in the store
	localparam logic [5:0] OCL_WI_DEVTYPE = 6'h00;
	localparam logic [5:0] OCL_WI_VID = 6'h01;
	localparam logic [5:0] OCL_WI_PID = 6'h02;
	localparam logic [5:0] OCL_WI_FLAGS = 6'h03;
	localparam logic [5:0] OCL_WI_POWER = 6'h04;
	localparam logic [5:0] OCL_WI_SLAVE = 6'h05;
	localparam logic [5:0] OCL_STR_MFR_BASE = 6'h08;
	localparam logic [5:0] OCL_STR_PROD_BASE = 6'h10;
	localparam logic [5:0] OCL_STR_SER_BASE = 6'h18;

	// ==========================================================
	// Bit positions in the flags word
	localparam int OCL_FB_SELF_PWR = 0;
	localparam int OCL_FB_WAKE = 1;
	localparam int OCL_FB_SERIAL = 2;
	localparam int OCL_FB_SUSP_EN = 3;
	localparam int OCL_FB_SUSP_POL = 4;
	localparam int OCL_FB_SER_MODE = 5;
	localparam int OCL_FB_SER_SUSP = 6;
	localparam int OCL_FB_PIN_SUSP = 8;
	localparam int OCL_FB_OPEN_DRAIN = 10;
	localparam int OCL_FB_CHG_DIS = 11;
	localparam int OCL_FB_CHG_POL = 12;
	localparam int OCL_FB_EDGE = 13;

	// ==========================================================
	// Suspend behaviour codes
	localparam logic [1:0] OCL_SUSP_KEEP = 2'h0;
	localparam logic [1:0] OCL_SUSP_TRI = 2'h1;
	localparam logic [1:0] OCL_SUSP_HIGH = 2'h2;
	localparam logic [1:0] OCL_SUSP_LOW = 2'h3;

	// ==========================================================
	// Factory values
	localparam logic [15:0] OCL_DEF_DEVTYPE = 16'h0042; // Arbitrary value
	localparam logic [15:0] OCL_DEF_VID = 16'h1234; // Arbitrary value
	localparam logic [15:0] OCL_DEF_PID = 16'h5678; // Arbitrary value
	localparam logic [15:0] OCL_DEF_FLAGS = 16'h010A;
	localparam logic [15:0] OCL_DEF_POWER = 16'h0064;
	localparam logic [15:0] OCL_DEF_SLAVE = 16'h0040;
	localparam logic [15:0] OCL_USB_VERSION = 16'h0200;
	localparam logic [8:0] OCL_MAX_CURRENT = 9'h1F4;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OCL_REG_STATUS = 8'h00;
	localparam logic [7:0] OCL_REG_CTRL = 8'h04;
	localparam logic [7:0] OCL_REG_IDS = 8'h08;
	localparam logic [7:0] OCL_REG_INFO = 8'h0C;
	localparam logic [7:0] OCL_REG_FLAGS = 8'h10;
	localparam logic [7:0] OCL_REG_POWER = 8'h14;

	// ==========================================================
	// Loader states
	typedef enum logic [4:0] {
		OCL_ST_IDLE = 5'b00001,
		OCL_ST_READ = 5'b00010,
		OCL_ST_WAIT = 5'b00100,
		OCL_ST_COMMIT = 5'b01000,
		OCL_ST_STR = 5'b10000
	} ocl_state_t;

endpackage

// ==== test_otp_config_loader.sv ====
// Self-checking bench of the configuration loader: bus reads, reloads,
// strings, suspend pin shaping, charger output and wake edge.
// Assumes the store holds its factory contents.
`timescale 1ns/1ps
`default_nettype none
module test_otp_config_loader;
	import ocl_pkg::*;
	// ==========================================================
	// Signals
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic usb_reset_i = 1'b0, usb_suspend = 1'b0, dcp_detect = 1'b0;
	logic desc_valid, desc_self_powered, desc_remote_wake, desc_serial_en;
	logic [15:0] desc_vid, desc_pid, desc_version, dev_type;
	logic [8:0] desc_max_current;
	logic str_req, str_ack, str_ok, ok;
	logic [1:0] str_sel;
	logic [2:0] str_idx;
	logic [7:0] str_char, ch;
	logic [6:0] slave_addr;
	logic [3:0] gpio_out_i = 4'h0, gpio_oe_i = 4'h0, pin_out, pin_oe;
	logic interrupt_wake_function = 1'b0, general_pin_three = 1'b0;
	logic wake_pulse, charger_detect_out;
	logic [5:0] ser_out_i = 6'h0, ser_oe_i = 6'h0, ser_pin_out, ser_pin_oe;
	logic [31:0] rng_q = 32'h616B41F8;
	int err_count = 0, cmp_count = 0;
	int str_len [3] = '{4, 6, 4};
	bit exp_ok_q [$];
	string str_txt [3] = '{"ACME", "BRIDGE", "0001"};

	// Clock and the single slave's ready
	always #50 clk_sys = ~clk_sys;
	assign hready = hreadyout;

	// ==========================================================
	// Design and host model
	ocl_loader #(.SER_PINS(6)) dut_u (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.usb_reset_i(usb_reset_i), .usb_suspend(usb_suspend), .dcp_detect(dcp_detect),
		.desc_valid(desc_valid), .desc_vid(desc_vid), .desc_pid(desc_pid),
		.desc_version(desc_version), .dev_type(dev_type),
		.desc_self_powered(desc_self_powered), .desc_max_current(desc_max_current),
		.desc_remote_wake(desc_remote_wake), .desc_serial_en(desc_serial_en),
		.str_req(str_req), .str_sel(str_sel), .str_idx(str_idx), .str_ack(str_ack),
		.str_ok(str_ok), .str_char(str_char), .slave_addr(slave_addr),
		.gpio_out_i(gpio_out_i), .gpio_oe_i(gpio_oe_i), .pin_out(pin_out), .pin_oe(pin_oe),
		.interrupt_wake_function(interrupt_wake_function),
		.general_pin_three(general_pin_three), .wake_pulse(wake_pulse),
		.ser_out_i(ser_out_i), .ser_oe_i(ser_oe_i), .ser_pin_out(ser_pin_out),
		.ser_pin_oe(ser_pin_oe), .charger_detect_out(charger_detect_out));
	ocl_host_model host_u (.clk_sys(clk_sys), .str_ack(str_ack), .str_ok(str_ok),
		.str_char(str_char), .str_req(str_req), .str_sel(str_sel), .str_idx(str_idx));

	// ==========================================================
	// Shared tasks
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Single AHB-Lite word transfer; read data taken in the data phase
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rdv);
		@(posedge clk_sys);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		do
			@(posedge clk_sys);
		while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do
			@(posedge clk_sys);
		while (hready !== 1'b1);
		rdv = hrdata;
	endtask

	task automatic wait_valid(input logic lvl, input int lim);
		int n;
		n = 0;
		while (desc_valid !== lvl && n < lim)
		begin
			@(negedge clk_sys);
			n++;
		end
		chk("desc_valid", {31'h0, lvl}, {31'h0, desc_valid});
	endtask

	// Restart the load and ask for a string at once: no answer before commit
	task automatic reload(input bit by_usb);
		if (by_usb)
		begin
			@(posedge clk_sys);
			usb_reset_i <= 1'b1;
			@(posedge clk_sys);
			usb_reset_i <= 1'b0;
		end
		else
			ahb(1'b1, OCL_REG_CTRL, 32'h1, rd);
		wait_valid(1'b0, 6);
		host_u.fetch(2'h1, 3'h0, 0, ok, ch);
		chk("valid_at_ack", 1, desc_valid);
		chk("str_ok", 1, ok);
		chk("str_char", 8'h42, ch);
		chk("vid", OCL_DEF_VID, desc_vid);
	endtask

	task automatic wake_test(input logic lvl, input logic exp);
		logic seen;
		seen = 1'b0;
		@(posedge clk_sys);
		general_pin_three <= lvl;
		repeat (8)
		begin
			@(negedge clk_sys);
			if (wake_pulse === 1'b1)
				seen = 1'b1;
		end
		chk("wake_pulse", exp, seen);
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (3) @(posedge clk_sys);
		chk("desc_valid", 0, desc_valid);
		rstn <= 1'b1;
		wait_valid(1'b1, 40);
		chk("vid", OCL_DEF_VID, desc_vid);
		chk("pid", OCL_DEF_PID, desc_pid);
		chk("version", OCL_USB_VERSION, desc_version);
		chk("dev_type", OCL_DEF_DEVTYPE, dev_type);
		chk("self_powered", 0, desc_self_powered);
		chk("max_current", 100, desc_max_current);
		chk("remote_wake", 1, desc_remote_wake);
		chk("serial_en", 0, desc_serial_en);
		chk("slave_addr", 7'h40, slave_addr);
		$display("test load done");
		ahb(1'b0, OCL_REG_IDS, 0, rd);
		chk("ids", {OCL_DEF_VID, OCL_DEF_PID}, rd);
		rng_q = xs(rng_q);
		ahb(1'b1, OCL_REG_INFO, rng_q, rd);
		ahb(1'b1, 8'h20, ~rng_q, rd);
		ahb(1'b0, OCL_REG_INFO, 0, rd);
		chk("info", {OCL_DEF_DEVTYPE, OCL_USB_VERSION}, rd);
		ahb(1'b0, OCL_REG_FLAGS, 0, rd);
		chk("flags", {16'h0, OCL_DEF_FLAGS}, rd);
		ahb(1'b0, OCL_REG_POWER, 0, rd);
		chk("power", 32'h00400064, rd);
		ahb(1'b0, 8'h20, 0, rd);
		chk("unmapped", 0, rd);
		ahb(1'b0, OCL_REG_STATUS, 0, rd);
		chk("status", 32'h1, rd);
		chk("hresp", 0, hresp);
		$display("test regs done");
		reload(1'b0);
		reload(1'b1);
		$display("test reload done");
		// Model of which strings answer, per character
		for (int s = 0; s < 3; s++)
			for (int i = 0; i < str_len[s]; i++)
				exp_ok_q.push_back(s != 2);
		for (int s = 0; s < 3; s++)
			for (int i = 0; i < str_len[s]; i++)
			begin
				host_u.fetch(s[1:0], i[2:0], i % 3, ok, ch);
				chk("str_ok", exp_ok_q.pop_front(), ok);
				if (s != 2)
					chk("str_char", str_txt[s][i], ch);
			end
		$display("test strings done");
		for (int k = 0; k < 8; k++)
		begin
			rng_q = xs(rng_q);
			@(posedge clk_sys);
			usb_suspend <= k[0];
			dcp_detect <= k[1];
			gpio_out_i <= rng_q[7:4];
			gpio_oe_i <= rng_q[11:8];
			ser_out_i <= rng_q[17:12];
			ser_oe_i <= rng_q[23:18];
			repeat (5) @(negedge clk_sys);
			if (k[0])
			begin
				chk("pin_oe", 4'h4, pin_oe);
				chk("pin_two", 1, pin_out[2]);
				chk("ser_oe", 0, ser_pin_oe);
			end
			else
			begin
				chk("pin_oe", {rng_q[11], 1'b1, rng_q[9:8]}, pin_oe);
				chk("pin_out", {rng_q[7], 1'b0, rng_q[5:4]}, pin_out);
				chk("ser_out", rng_q[17:12], ser_pin_out);
				chk("ser_oe", rng_q[23:18], ser_pin_oe);
			end
			chk("charger", k[0] & k[1], charger_detect_out);
		end
		@(posedge clk_sys);
		usb_suspend <= 1'b0;
		dcp_detect <= 1'b0;
		$display("test pins done");
		interrupt_wake_function <= 1'b1;
		wake_test(1'b1, 1'b1);
		wake_test(1'b0, 1'b0);
		@(posedge clk_sys);
		interrupt_wake_function <= 1'b0;
		wake_test(1'b1, 1'b0);
		$display("test wake done");
		// Power-on reset in mid-run must drop the settings and load them again
		@(posedge clk_sys);
		rstn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk("desc_valid", 0, desc_valid);
		rstn <= 1'b1;
		wait_valid(1'b1, 40);
		chk("vid", OCL_DEF_VID, desc_vid);
		$display("test reset done");
		close_out();
	end

	// Watchdog against a hung handshake
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		err_count++;
		close_out();
	end
endmodule
`default_nettype wire
